// *** verification/nal_mem_model.sv ***
`timescale 1ns/1ps

// nibble memory on the far side: bench preset or block write pulse
module nal_mem_model (
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  input  wire logic [1:0] ptr_in,
  input  wire logic       load_in,
  input  wire logic [3:0] load_data_in,
  input  wire logic       wr_in,
  input  wire logic [3:0] wdata_in,
  output logic      [3:0] nibble_out
);
  logic [3:0] cell_q [4];

  // a write lands on the edge where the pulse is seen
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 4; i++) cell_q[i] <= 4'h0;
    end else if (load_in) begin
      cell_q[ptr_in] <= load_data_in;
    end else if (wr_in) begin
      cell_q[ptr_in] <= wdata_in;
    end
  end

  // read of the nibble at the pointer
  assign nibble_out = cell_q[ptr_in];
endmodule

// *** verification/nibble_alu_skip_logic_tb.sv ***
`timescale 1ns/1ps

module nibble_alu_skip_logic_tb;
  logic             clock_in;
  logic             arst_n_in;
  logic             op_valid_in;
  nal_pkg::nal_op_e op_in;
  logic [3:0]       imm_in;
  logic [3:0]       acc;
  logic [3:0]       wdata;
  logic [3:0]       nib;
  logic [3:0]       ld_data;
  logic [1:0]       ptr;
  logic             ld;
  logic             carry;
  logic             wr;
  logic             skip;
  logic [3:0]       e_acc;
  logic [3:0]       e_wd;
  logic [3:0]       e_mem [4];
  logic             e_carry;
  logic             e_skip;
  int               fails;
  int               n_tests;

  nal_alu_top u_dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .op_valid_in(op_valid_in), .op_in(op_in), .imm_in(imm_in),
    .mem_nibble_in(nib), .acc_out(acc), .carry_flag_out(carry),
    .mem_wr_out(wr), .mem_wdata_out(wdata), .skip_out(skip));
  nal_mem_model u_mem (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .ptr_in(ptr), .load_in(ld), .load_data_in(ld_data), .wr_in(wr),
    .wdata_in(wdata), .nibble_out(nib));

  // free-running clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task chk(input string nm, input logic [3:0] s, input logic [3:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task idle;
    op_valid_in = 1'b0;
    @(posedge clock_in);
    #1;
    chk("wr_idle", {3'h0, wr}, 4'h0);
  endtask

  task preset(input logic [1:0] p, input logic [3:0] v);
    op_valid_in = 1'b0;
    ptr = p;
    ld = 1'b1;
    ld_data = v;
    e_mem[p] = v;
    @(posedge clock_in);
    #1;
    ld = 1'b0;
  endtask

  // one operation, expected state worked out alongside
  task issue(input nal_pkg::nal_op_e op, input logic [3:0] n);
    logic [4:0] s;
    logic [3:0] m;
    logic       w;
    m = e_mem[ptr];
    s = {1'b0, e_acc} + {1'b0, n};
    w = 1'b0;
    op_valid_in = 1'b1;
    op_in = op;
    imm_in = n;
    if (e_skip) begin
      e_skip = 1'b0;
    end else begin
      e_skip = 1'b0;
      case (op)
        nal_pkg::NAL_OP_ADDI: {e_skip, e_acc} = {~s[4], s[3:0]};
        nal_pkg::NAL_OP_AND: e_acc = e_acc & m;
        nal_pkg::NAL_OP_OR: e_acc = e_acc | m;
        nal_pkg::NAL_OP_SETC: e_carry = 1'b1;
        nal_pkg::NAL_OP_CLRC: e_carry = 1'b0;
        nal_pkg::NAL_OP_TESTC: e_skip = ~e_carry;
        nal_pkg::NAL_OP_CMPL: e_acc = ~e_acc;
        nal_pkg::NAL_OP_ROTR: {e_acc, e_carry} = {e_carry, e_acc};
        nal_pkg::NAL_OP_BSET: {w, e_wd} = {1'b1, m | (4'h1 << n[1:0])};
        nal_pkg::NAL_OP_BCLR: {w, e_wd} = {1'b1, m & ~(4'h1 << n[1:0])};
        nal_pkg::NAL_OP_BTST: e_skip = ~m[n[1:0]];
        nal_pkg::NAL_OP_CMPM: e_skip = (e_acc == m);
        nal_pkg::NAL_OP_CMPI: e_skip = (e_acc == n);
        default: e_skip = 1'b0;
      endcase
    end
    @(posedge clock_in);
    #1;
    chk("acc", acc, e_acc);
    chk("carry", {3'h0, carry}, {3'h0, e_carry});
    chk("skip", {3'h0, skip}, {3'h0, e_skip});
    chk("wr", {3'h0, wr}, {3'h0, w});
    // write data holds between writes, so it is compared every time
    chk("wdata", wdata, e_wd);
    if (w) begin
      e_mem[ptr] = e_wd;
      idle();
    end
  endtask

  // load accumulator: clear by AND with zero, add, drop the skip
  task set_acc(input logic [3:0] v);
    preset(2'h3, 4'h0);
    issue(nal_pkg::NAL_OP_AND, 4'h0);
    issue(nal_pkg::NAL_OP_ADDI, v);
    issue(nal_pkg::NAL_OP_NOP, 4'h0);
  endtask

  task t_add;
    issue(nal_pkg::NAL_OP_SETC, 4'h0);
    set_acc(4'h9);
    for (int i = 0; i < 16; i++) begin
      issue(nal_pkg::NAL_OP_ADDI, i[3:0]);
      issue(nal_pkg::NAL_OP_CMPL, 4'h0);
    end
    $display("t_add done");
  endtask

  task t_carry;
    issue(nal_pkg::NAL_OP_CLRC, 4'h0);
    issue(nal_pkg::NAL_OP_TESTC, 4'h0);
    issue(nal_pkg::NAL_OP_SETC, 4'h0);
    issue(nal_pkg::NAL_OP_SETC, 4'h0);
    issue(nal_pkg::NAL_OP_TESTC, 4'h0);
    set_acc(4'h5);
    for (int i = 0; i < 5; i++) issue(nal_pkg::NAL_OP_ROTR, 4'h0);
    issue(nal_pkg::NAL_OP_CLRC, 4'h0);
    issue(nal_pkg::NAL_OP_TESTC, 4'h0);
    issue(nal_pkg::NAL_OP_ADDI, 4'hf);
    $display("t_carry done");
  endtask

  task t_logic;
    set_acc(4'h6);
    preset(2'h0, 4'hc);
    issue(nal_pkg::NAL_OP_OR, 4'h0);
    issue(nal_pkg::NAL_OP_CMPM, 4'h0);
    issue(nal_pkg::NAL_OP_CMPM, 4'h0);
    issue(nal_pkg::NAL_OP_AND, 4'h0);
    issue(nal_pkg::NAL_OP_CMPI, 4'h3);
    issue(nal_pkg::NAL_OP_CMPI, e_acc);
    issue(nal_pkg::NAL_OP_CMPL, 4'h0);
    issue(nal_pkg::NAL_OP_CMPM, 4'h0);
    issue(nal_pkg::NAL_OP_NOP, 4'h0);
    $display("t_logic done");
  endtask

  task t_bits;
    preset(2'h1, 4'h5);
    for (int j = 0; j < 4; j++) begin
      issue(nal_pkg::NAL_OP_BSET, {2'b10, j[1:0]});
      issue(nal_pkg::NAL_OP_BTST, {2'b01, j[1:0]});
      issue(nal_pkg::NAL_OP_BCLR, {2'b11, j[1:0]});
      issue(nal_pkg::NAL_OP_BTST, {2'b00, j[1:0]});
      issue(nal_pkg::NAL_OP_BSET, {2'b00, j[1:0]});
    end
    $display("t_bits done");
  endtask

  // mid-run reset: state falls to zero without a clock edge
  task t_reset;
    issue(nal_pkg::NAL_OP_SETC, 4'h0);
    issue(nal_pkg::NAL_OP_BSET, 4'h3);
    issue(nal_pkg::NAL_OP_CMPI, e_acc);
    arst_n_in = 1'b0;
    #1;
    chk("rst_acc", acc, 4'h0);
    chk("rst_flags", {1'b0, carry, skip, wr}, 4'h0);
    chk("rst_wdata", wdata, 4'h0);
    repeat (2) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    {e_acc, e_wd, e_carry, e_skip} = '0;
    for (int i = 0; i < 4; i++) e_mem[i] = 4'h0;
    issue(nal_pkg::NAL_OP_NOP, 4'h0);
    issue(nal_pkg::NAL_OP_CMPM, 4'h0);
    issue(nal_pkg::NAL_OP_NOP, 4'h0);
    $display("t_reset done");
  endtask

  // reset, then the scenarios
  initial begin
    {arst_n_in, op_valid_in, ld, ptr, ld_data, imm_in} = '0;
    op_in = nal_pkg::NAL_OP_NOP;
    {e_acc, e_wd, e_carry, e_skip, fails, n_tests} = '0;
    for (int i = 0; i < 4; i++) e_mem[i] = 4'h0;
    repeat (8) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    t_add();
    t_carry();
    t_logic();
    t_bits();
    t_reset();
    end_sim();
  end
endmodule

// *** verilog/nal_alu.sv ***
`timescale 1ns/1ps

// combinational datapath: next accumulator, carry, memory nibble, skip
module nal_alu #(
  parameter int DATA_W = 4
) (
  nal_alu_if.alu alu
);
  localparam int IDX_W = $clog2(DATA_W);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // one-hot mask of the bit named by the low immediate bits
  function automatic logic [DATA_W-1:0] bit_mask(
    input logic [DATA_W-1:0] imm
  );
    logic [DATA_W-1:0] m;
    m = '0;
    m[imm[IDX_W-1:0]] = 1'b1;
    return m;
  endfunction

  logic [DATA_W:0] sum;

  // ----------------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------------
  always_comb begin
    sum             = {1'b0, alu.acc} + {1'b0, alu.imm};
    alu.acc_d       = alu.acc;
    alu.carry_d     = alu.carry_flag;
    alu.mem_wr_d    = 1'b0;
    alu.mem_wdata_d = alu.mem_nibble;
    alu.skip_d      = 1'b0;
    unique case (alu.op)
      nal_pkg::NAL_OP_NOP: begin
      end
      nal_pkg::NAL_OP_ADDI: begin
        alu.acc_d  = sum[DATA_W-1:0];
        alu.skip_d = ~sum[DATA_W];
      end
      nal_pkg::NAL_OP_AND: begin
        alu.acc_d = alu.acc & alu.mem_nibble;
      end
      nal_pkg::NAL_OP_OR: begin
        alu.acc_d = alu.acc | alu.mem_nibble;
      end
      nal_pkg::NAL_OP_SETC: begin
        alu.carry_d = 1'b1;
      end
      nal_pkg::NAL_OP_CLRC: begin
        alu.carry_d = 1'b0;
      end
      nal_pkg::NAL_OP_TESTC: begin
        alu.skip_d = ~alu.carry_flag;
      end
      nal_pkg::NAL_OP_CMPL: begin
        alu.acc_d = ~alu.acc;
      end
      nal_pkg::NAL_OP_ROTR: begin
        alu.acc_d   = {alu.carry_flag, alu.acc[DATA_W-1:1]};
        alu.carry_d = alu.acc[0];
      end
      nal_pkg::NAL_OP_BSET: begin
        alu.mem_wr_d    = 1'b1;
        alu.mem_wdata_d = alu.mem_nibble | bit_mask(alu.imm);
      end
      nal_pkg::NAL_OP_BCLR: begin
        alu.mem_wr_d    = 1'b1;
        alu.mem_wdata_d = alu.mem_nibble & ~bit_mask(alu.imm);
      end
      nal_pkg::NAL_OP_BTST: begin
        alu.skip_d = ~|(alu.mem_nibble & bit_mask(alu.imm));
      end
      nal_pkg::NAL_OP_CMPM: begin
        alu.skip_d = (alu.acc == alu.mem_nibble);
      end
      nal_pkg::NAL_OP_CMPI: begin
        alu.skip_d = (alu.acc == alu.imm);
      end
      default: begin
      end
    endcase
  end
endmodule

// *** verilog/nal_alu_if.sv ***
`timescale 1ns/1ps

// operands in, next state out, between top and combinational datapath
interface nal_alu_if #(
  parameter int DATA_W = 4
);
  nal_pkg::nal_op_e    op;
  logic [DATA_W-1:0]   imm;
  logic [DATA_W-1:0]   mem_nibble;
  logic [DATA_W-1:0]   acc;
  logic                carry_flag;
  logic [DATA_W-1:0]   acc_d;
  logic                carry_d;
  logic                mem_wr_d;
  logic [DATA_W-1:0]   mem_wdata_d;
  logic                skip_d;

  modport core (
    output op, imm, mem_nibble, acc, carry_flag,
    input  acc_d, carry_d, mem_wr_d, mem_wdata_d, skip_d
  );
  modport alu (
    input  op, imm, mem_nibble, acc, carry_flag,
    output acc_d, carry_d, mem_wr_d, mem_wdata_d, skip_d
  );
endinterface

// *** verilog/nal_alu_top.sv ***
// Function
// - add immediate into accumulator
// - add immediate keeps carry flag
// - add immediate skips when no overflow
// - accumulator ANDed with memory nibble
// - accumulator ORed with memory nibble
// - set carry flag to one
// - clear carry flag to zero
// - skip next when carry flag zero
// - complement accumulator, carry untouched
// - rotate carry and accumulator right
// - set selected memory nibble bit
// - clear selected memory nibble bit
// - skip when selected memory bit zero
// - skip when accumulator equals memory
// - skip when accumulator equals immediate
`timescale 1ns/1ps
`include "nal_defines.svh"

module nal_alu_top #(
  parameter int DATA_W = `NAL_DATA_W
) (
  input  wire logic              clock_in,
  input  wire logic              arst_n_in,
  input  wire logic              op_valid_in,
  input  wire nal_pkg::nal_op_e  op_in,
  input  wire logic [DATA_W-1:0] imm_in,
  input  wire logic [DATA_W-1:0] mem_nibble_in,
  output logic      [DATA_W-1:0] acc_out,
  output logic                   carry_flag_out,
  output logic                   mem_wr_out,
  output logic      [DATA_W-1:0] mem_wdata_out,
  output logic                   skip_out
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (DATA_W < 2 || (DATA_W & (DATA_W - 1)) != 0) begin : g_bad_width
    $error("nal_alu_top: DATA_W must be a power of two, at least 2");
  end

  logic [DATA_W-1:0] acc_q;
  logic              carry_q;
  logic              skip_q;
  logic              mem_wr_q;
  logic [DATA_W-1:0] mem_wdata_q;
  logic              exec;

  nal_alu_if #(.DATA_W(DATA_W)) alu_bus ();

  // ----------------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------------
  assign alu_bus.op         = op_in;
  assign alu_bus.imm        = imm_in;
  assign alu_bus.mem_nibble = mem_nibble_in;
  assign alu_bus.acc        = acc_q;
  assign alu_bus.carry_flag = carry_q;

  nal_alu #(.DATA_W(DATA_W)) u_alu (
    .alu (alu_bus.alu)
  );

  // an operation takes effect only when it is not the skipped one
  assign exec = op_valid_in & ~skip_q;

  // ----------------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------------
  // accumulator and carry flag
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_q   <= `NAL_ACC_RST;
      carry_q <= `NAL_CARRY_RST;
    end else if (exec) begin
      acc_q   <= alu_bus.acc_d;
      carry_q <= alu_bus.carry_d;
    end
  end

  // memory nibble write-back, one pulse per bit set or clear
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_wr_q    <= `NAL_MEM_WR_RST;
      mem_wdata_q <= `NAL_MEM_DAT_RST;
    end else begin
      mem_wr_q <= exec & alu_bus.mem_wr_d;
      if (exec && alu_bus.mem_wr_d) begin
        mem_wdata_q <= alu_bus.mem_wdata_d;
      end
    end
  end

  // skip marker: the next valid instruction is consumed without effect
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      skip_q <= `NAL_SKIP_RST;
    end else if (op_valid_in) begin
      skip_q <= exec & alu_bus.skip_d;
    end
  end

  assign acc_out        = acc_q;
  assign carry_flag_out = carry_q;
  assign mem_wr_out     = mem_wr_q;
  assign mem_wdata_out  = mem_wdata_q;
  assign skip_out       = skip_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  logic [DATA_W:0]   chk_sum;
  logic [DATA_W-1:0] chk_mask;
  logic              chk_skip_op;
  assign chk_sum  = {1'b0, acc_q} + {1'b0, imm_in};
  assign chk_mask = DATA_W'(1) << imm_in[$clog2(DATA_W)-1:0];
  // operations that are allowed to raise the skip marker
  assign chk_skip_op = op_in inside {nal_pkg::NAL_OP_ADDI,
    nal_pkg::NAL_OP_TESTC, nal_pkg::NAL_OP_BTST, nal_pkg::NAL_OP_CMPM,
    nal_pkg::NAL_OP_CMPI};

  sequence s_run(nal_pkg::nal_op_e code);
    op_valid_in && !skip_q && op_in == code;
  endsequence

  sequence s_squashed;
    op_valid_in && skip_q;
  endsequence

  // cycle with no instruction presented
  sequence s_idle;
    !op_valid_in;
  endsequence

  // cycle that cannot start a bit write
  sequence s_no_write;
    !op_valid_in || skip_q
      || !(op_in inside {nal_pkg::NAL_OP_BSET, nal_pkg::NAL_OP_BCLR});
  endsequence

  a_addi_sum: assert property (
    s_run(nal_pkg::NAL_OP_ADDI) |=> acc_q == $past(chk_sum[DATA_W-1:0]))
    else $error("add immediate sum wrong");
  a_addi_carry_kept: assert property (
    s_run(nal_pkg::NAL_OP_ADDI) |=> $stable(carry_q))
    else $error("add immediate changed carry");
  a_addi_skip: assert property (
    s_run(nal_pkg::NAL_OP_ADDI) |=> skip_q == !$past(chk_sum[DATA_W]))
    else $error("add immediate skip wrong");
  a_and_result: assert property (
    s_run(nal_pkg::NAL_OP_AND)
      |=> acc_q == ($past(acc_q) & $past(mem_nibble_in)))
    else $error("and result wrong");
  a_or_result: assert property (
    s_run(nal_pkg::NAL_OP_OR)
      |=> acc_q == ($past(acc_q) | $past(mem_nibble_in)))
    else $error("or result wrong");
  a_carry_set: assert property (
    s_run(nal_pkg::NAL_OP_SETC) |=> carry_q && $stable(acc_q) && !mem_wr_q)
    else $error("set carry wrong");
  a_carry_clear: assert property (
    s_run(nal_pkg::NAL_OP_CLRC) |=> !carry_q && $stable(acc_q) && !mem_wr_q)
    else $error("clear carry wrong");
  a_carry_test: assert property (
    s_run(nal_pkg::NAL_OP_TESTC) |=> skip_q == !$past(carry_q))
    else $error("carry test skip wrong");
  a_cmpl_result: assert property (
    s_run(nal_pkg::NAL_OP_CMPL) |=> acc_q == ~$past(acc_q) && $stable(carry_q))
    else $error("complement wrong");
  a_rot_chain: assert property (
    s_run(nal_pkg::NAL_OP_ROTR)
      |=> {acc_q, carry_q} == {$past(carry_q), $past(acc_q)})
    else $error("rotate wrong");
  a_bit_set: assert property (
    s_run(nal_pkg::NAL_OP_BSET)
      |=> mem_wr_q && mem_wdata_q == ($past(mem_nibble_in) | $past(chk_mask)))
    else $error("bit set wrong");
  a_bit_clear: assert property (
    s_run(nal_pkg::NAL_OP_BCLR)
      |=> mem_wr_q && mem_wdata_q == ($past(mem_nibble_in) & ~$past(chk_mask)))
    else $error("bit clear wrong");
  a_bit_test: assert property (
    s_run(nal_pkg::NAL_OP_BTST)
      |=> skip_q == ($past(mem_nibble_in & chk_mask) == '0))
    else $error("bit test skip wrong");
  a_cmp_mem: assert property (
    s_run(nal_pkg::NAL_OP_CMPM)
      |=> skip_q == ($past(acc_q) == $past(mem_nibble_in)))
    else $error("memory compare skip wrong");
  a_cmp_imm: assert property (
    s_run(nal_pkg::NAL_OP_CMPI) |=> skip_q == ($past(acc_q) == $past(imm_in)))
    else $error("immediate compare skip wrong");
  a_skip_no_effect: assert property (
    s_squashed
      |=> $stable(acc_q) && $stable(carry_q) && !mem_wr_q && !skip_q)
    else $error("skipped instruction changed state");

  // state that must hold when nothing is executed or nothing is its target
  a_idle_hold: assert property (
    s_idle |=> $stable(acc_q) && $stable(carry_q) && $stable(skip_q)
      && !mem_wr_q)
    else $error("state changed with no instruction");
  a_wr_bit_only: assert property (
    s_no_write |=> !mem_wr_q)
    else $error("write pulse without a bit operation");
  a_wdata_hold: assert property (
    !mem_wr_q |-> $stable(mem_wdata_q))
    else $error("write data moved without a write");
  a_skip_source: assert property (
    $rose(skip_q) |-> $past(op_valid_in && chk_skip_op))
    else $error("skip raised by a non-skip operation");
  a_bset_keep: assert property (
    s_run(nal_pkg::NAL_OP_BSET)
      |=> $stable(acc_q) && $stable(carry_q) && !skip_q)
    else $error("bit set changed other state");
  a_bclr_keep: assert property (
    s_run(nal_pkg::NAL_OP_BCLR)
      |=> $stable(acc_q) && $stable(carry_q) && !skip_q)
    else $error("bit clear changed other state");
  a_cmpm_keep: assert property (
    s_run(nal_pkg::NAL_OP_CMPM)
      |=> $stable(acc_q) && $stable(carry_q) && !mem_wr_q)
    else $error("memory compare changed other state");
  a_cmpi_keep: assert property (
    s_run(nal_pkg::NAL_OP_CMPI)
      |=> $stable(acc_q) && $stable(carry_q) && !mem_wr_q)
    else $error("immediate compare changed other state");

endmodule

// *** verilog/nal_defines.svh ***
`ifndef NAL_DEFINES_SVH
`define NAL_DEFINES_SVH

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define NAL_DATA_W      4
`define NAL_ACC_RST     4'h0
`define NAL_CARRY_RST   1'b0
`define NAL_SKIP_RST    1'b0
`define NAL_MEM_WR_RST  1'b0
`define NAL_MEM_DAT_RST 4'h0

`endif

// *** verilog/nal_pkg.sv ***
package nal_pkg;

  // ----------------------------------------------------------------------
  // operation codes from the instruction decoder
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    NAL_OP_NOP   = 4'h0,
    NAL_OP_ADDI  = 4'h1,
    NAL_OP_AND   = 4'h2,
    NAL_OP_OR    = 4'h3,
    NAL_OP_SETC  = 4'h4,
    NAL_OP_CLRC  = 4'h5,
    NAL_OP_TESTC = 4'h6,
    NAL_OP_CMPL  = 4'h7,
    NAL_OP_ROTR  = 4'h8,
    NAL_OP_BSET  = 4'h9,
    NAL_OP_BCLR  = 4'ha,
    NAL_OP_BTST  = 4'hb,
    NAL_OP_CMPM  = 4'hc,
    NAL_OP_CMPI  = 4'hd
  } nal_op_e;

endpackage
